// File: fss_div.sv
// Purpose: Restoring divider for the deceleration slope.
// Assumes: start only while idle; den of zero gives all ones.
// Notes: done pulses on the same clock edge as the last step.
`timescale 1ns/10ps

// ==============================
// Divider
module fss_div (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic [15:0] num,
  input wire logic [15:0] den,
  output logic done,
  output logic [15:0] quo
);
  import fss_pkg::*;

  logic [16:0] rem_r;
  logic [15:0] q_r;
  logic [4:0] cnt_r;
  logic [16:0] shifted;
  logic [16:0] trial;

  // One quotient bit per clock
  assign shifted = {rem_r[15:0], q_r[15]};
  assign trial = shifted - {1'b0, den};

  // Iteration state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rem_r <= 17'h00000;
      q_r <= 16'h0000;
      cnt_r <= 5'h00;
    end
    else if (start && cnt_r == 5'h00)
    begin
      rem_r <= 17'h00000;
      q_r <= num;
      cnt_r <= 5'(DIV_STEPS);
    end
    else if (cnt_r != 5'h00)
    begin
      cnt_r <= cnt_r - 5'h01;
      if (!trial[16])
      begin
        rem_r <= trial;
        q_r <= {q_r[14:0], 1'b1};
      end
      else
      begin
        rem_r <= shifted;
        q_r <= {q_r[14:0], 1'b0};
      end
    end
  end

  // Completion pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      done <= 1'b0;
    else
      done <= (cnt_r == 5'h01);
  end

  assign quo = q_r;
endmodule : fss_div

// File: fss_motor_model.sv
// Purpose: Motor and speed sensor seen by the sequencer.
// Assumes: Speed follows the model command while driven.
// Notes: Unpowered motor coasts down by a fixed step.
`timescale 1ns/10ps

// ==============================
// Motor
module fss_motor_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic drive_enable,
  input wire logic [15:0] model_speed_cmd,
  output logic [15:0] speed_meas
);
  // Follow when driven, else coast towards zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      speed_meas <= 16'h0000;
    else if (drive_enable)
      speed_meas <= model_speed_cmd;
    else if (speed_meas > 16'h0010)
      speed_meas <= speed_meas - 16'h0010;
    else
      speed_meas <= 16'h0000;
  end
endmodule : fss_motor_model

// File: fss_pkg.sv
// Purpose: Constants and types shared by the forced stop sequencer.
// Assumes: 200 MHz aclk; registers reached over AXI4-Lite.
// Notes: Speeds are unsigned magnitudes in one common unit.

// ==============================
// Package
package fss_pkg;
  // Clock and control cycle timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int CTRL_CYCLE_NS = 1000;
  localparam int CTRL_CYCLE_CLKS = (CTRL_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] TICK_LAST = 8'(CTRL_CYCLE_CLKS - 1);

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DECEL = 8'h04;
  localparam logic [7:0] OFF_ZSPD = 8'h08;
  localparam logic [7:0] OFF_SHUT = 8'h0C;
  localparam logic [7:0] OFF_COMP = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam logic [7:0] OFF_ALRM = 8'h18;
  localparam logic [7:0] OFF_MODEL = 8'h1C;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_TORQUE_BIT = 4;
  localparam int CTRL_ERST_BIT = 8;
  localparam int CTRL_CRST_BIT = 9;

  // Values after reset
  localparam logic [3:0] MODE_RST = 4'h2;
  localparam logic [15:0] DECEL_RST = 16'h0064;
  localparam logic [15:0] ZSPD_RST = 16'h0032;
  localparam logic [15:0] SHUT_RST = 16'h0000;
  localparam logic [15:0] COMP_RST = 16'h0000;

  // Stop mode leading digit codes
  localparam logic [3:0] MODE_DECEL = 4'h2;
  localparam logic [3:0] MODE_NO_DECEL = 4'h0;

  // Full scale speed used for the ramp slope
  localparam logic [15:0] RATED_SPEED = 16'h1770;
  localparam int DIV_STEPS = 16;

  // Display codes
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_WARN = 8'hE6;
  localparam logic [7:0] CODE_STO = 8'h63;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_DECEL = 4'b0010,
    ST_DELAY = 4'b0100,
    ST_OFF = 4'b1000
  } fss_state_t;

  typedef struct packed {
    logic [15:0] tc;
    logic [15:0] zspd;
    logic [15:0] delay;
    logic [15:0] comp;
  } fss_param_t;

  typedef struct packed {
    logic req;
    logic is_db;
    logic cause;
    logic [7:0] num;
  } fss_alarm_t;
endpackage : fss_pkg

// File: fss_seq.sv
// Purpose: Forced stop, alarm and link loss stop sequencer.
// Assumes: Inputs synchronous to aclk; speeds as magnitudes.
// Notes: Decisions other than direct braking are taken once per control cycle.
//
// Summary of operation
// - Forced stop: decelerate, then dynamic brake.
// - Show forced stop warning during sequence.
// - Ramp down at decel time constant rate.
// - Below zero speed: drive off, brake on.
// - Drop brake interlock, wait delay, drive off.
// - Lift only: amount set, delay on, stopped.
// - Lift shaft by amount during the delay.
// - Torque off during ramp raises timing alarm.
// - No ramp in torque control mode.
// - Link loss ramps, or brakes directly.
// - Mode digit 2 ramps, digit 0 not.
// - After alarm, ignore host, model goes zero.
// - Alarm clears on reset command, cause gone.
// - Brake-type alarms skip the ramp.
// - Brake alarm mid-ramp brakes at once.
`timescale 1ns/10ps

// ==============================
// Top
module fss_seq (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic forced_stop_input,
  input wire logic [15:0] speed_meas,
  input wire logic [15:0] host_speed_cmd,
  input wire fss_pkg::fss_alarm_t alarm_in,
  input wire logic link_lost,
  input wire logic link_lost_db,
  input wire logic sto_active,
  output logic drive_enable,
  output logic dyn_brake,
  output logic brake_interlock_output,
  output logic fault_output,
  output logic forced_stop_warning,
  output logic [7:0] display_code,
  output logic [15:0] model_speed_cmd,
  output logic [15:0] lift_offset
);
  import fss_pkg::*;

  // ==============================
  // Helpers
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'b00) && (a <= OFF_MODEL);
  endfunction : is_mapped

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // ==============================
  // Declarations
  logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic wr_go, wr_ok;
  logic [3:0] mode_r;
  logic torque_r;
  logic [15:0] tc_r, zspd_r, shut_r, comp_r;
  logic err_reset;
  logic [7:0] tick_cnt_r;
  logic tick, eval_r;
  fss_param_t par_s_r;
  logic [15:0] speed_s_r;
  logic div_done;
  logic [15:0] div_quo, step_r;
  logic alarm_act_r, alarm_db_r;
  logic [7:0] alarm_no_r;
  logic sto_err, alarm_set, alarm_clr;
  fss_state_t state_r;
  logic stop_event, decel_en, immediate_db, at_zero;
  logic leave_run, to_decel, decel_done, enter_delay;
  logic enter_off, delay_done, restart;
  logic [15:0] dly_cnt_r, model_r, lift_r;
  logic comp_ok_r;

  // ==============================
  // AXI4-Lite slave
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign wr_go = aw_held_r && w_held_r && !bvalid_r;
  assign wr_ok = wr_go && is_mapped(awaddr_r);

  // Address and data capture, either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end
    else if (wr_go)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= is_mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_r <= 1'b0;
  end

  // Read path, one word per address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_r <= 1'b1;
      rresp_r <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_axi_araddr)
        OFF_CTRL: rdata_r <= {27'h0000000, torque_r, mode_r};
        OFF_DECEL: rdata_r <= {16'h0000, tc_r};
        OFF_ZSPD: rdata_r <= {16'h0000, zspd_r};
        OFF_SHUT: rdata_r <= {16'h0000, shut_r};
        OFF_COMP: rdata_r <= {16'h0000, comp_r};
        OFF_STAT: rdata_r <= {20'h00000, comp_ok_r, forced_stop_warning, fault_output,
                              brake_interlock_output, dyn_brake, drive_enable, alarm_act_r, 1'b0, state_r};
        OFF_ALRM: rdata_r <= {16'h0000, alarm_no_r, display_code};
        OFF_MODEL: rdata_r <= {16'h0000, model_r};
        default: rdata_r <= 32'h00000000;
      endcase
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ==============================
  // Parameter registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_r <= MODE_RST;
      torque_r <= 1'b0;
      tc_r <= DECEL_RST;
      zspd_r <= ZSPD_RST;
      shut_r <= SHUT_RST;
      comp_r <= COMP_RST;
    end
    else if (wr_ok)
    begin
      unique case (awaddr_r)
        OFF_CTRL:
        begin
          if (wstrb_r[0])
          begin
            mode_r <= wdata_r[CTRL_MODE_LSB +: 4];
            torque_r <= wdata_r[CTRL_TORQUE_BIT];
          end
        end
        OFF_DECEL: tc_r <= merge16(tc_r, wdata_r, wstrb_r);
        OFF_ZSPD: zspd_r <= merge16(zspd_r, wdata_r, wstrb_r);
        OFF_SHUT: shut_r <= merge16(shut_r, wdata_r, wstrb_r);
        OFF_COMP: comp_r <= merge16(comp_r, wdata_r, wstrb_r);
        default:
        begin
        end
      endcase
    end
  end

  // Error reset or processor reset command pulse
  assign err_reset = wr_ok && (awaddr_r == OFF_CTRL) && wstrb_r[1]
                     && (wdata_r[CTRL_ERST_BIT] || wdata_r[CTRL_CRST_BIT]);

  // ==============================
  // Control cycle timing
  assign tick = (tick_cnt_r == TICK_LAST);

  // Cycle counter and evaluation strobe
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt_r <= 8'h00;
      eval_r <= 1'b0;
    end
    else
    begin
      tick_cnt_r <= tick ? 8'h00 : tick_cnt_r + 8'h01;
      eval_r <= tick;
    end
  end

  // Snapshot of parameters and speed at one instant
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      par_s_r <= '0;
      speed_s_r <= 16'h0000;
    end
    else if (tick)
    begin
      par_s_r <= '{tc: tc_r, zspd: zspd_r, delay: shut_r, comp: comp_r};
      speed_s_r <= speed_meas;
    end
  end

  // Ramp slope from the time constant
  fss_div u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(tick),
    .num(RATED_SPEED),
    .den(tc_r),
    .done(div_done),
    .quo(div_quo)
  );

  // Slope per control cycle, at least one unit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      step_r <= 16'h0001;
    else if (div_done)
      step_r <= (div_quo == 16'h0000) ? 16'h0001 : div_quo;
  end

  // ==============================
  // Alarm latch
  assign sto_err = sto_active && (state_r == ST_DECEL);
  assign alarm_set = alarm_in.req || sto_err;
  assign alarm_clr = err_reset && !alarm_in.cause;

  // Set wins over a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      alarm_act_r <= 1'b0;
      alarm_db_r <= 1'b0;
      alarm_no_r <= CODE_NONE;
    end
    else if (alarm_set)
    begin
      alarm_act_r <= 1'b1;
      alarm_no_r <= alarm_in.req ? alarm_in.num : CODE_STO;
      alarm_db_r <= alarm_db_r || (alarm_in.req && alarm_in.is_db);
    end
    else if (alarm_clr)
    begin
      alarm_act_r <= 1'b0;
      alarm_db_r <= 1'b0;
      alarm_no_r <= CODE_NONE;
    end
  end

  // ==============================
  // Sequence decisions
  assign stop_event = !forced_stop_input || alarm_act_r || link_lost;
  assign decel_en = (mode_r == MODE_DECEL) && !torque_r;
  assign immediate_db = (alarm_act_r && alarm_db_r) || link_lost_db;
  assign at_zero = speed_s_r <= par_s_r.zspd;
  assign leave_run = (state_r == ST_RUN) && eval_r && stop_event;
  assign to_decel = leave_run && decel_en && !at_zero;
  assign decel_done = (state_r == ST_DECEL) && eval_r && at_zero;
  assign enter_delay = ((leave_run && !to_decel) || decel_done) && (par_s_r.delay != 16'h0000);
  assign delay_done = (state_r == ST_DELAY) && eval_r && (dly_cnt_r <= 16'h0001);
  assign enter_off = ((leave_run && !to_decel) || decel_done) && (par_s_r.delay == 16'h0000);
  assign restart = (state_r == ST_OFF) && eval_r && !stop_event;

  // Stop sequence state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_r <= ST_OFF;
    else if (immediate_db)
      state_r <= ST_OFF;
    else
    begin
      unique case (state_r)
        ST_RUN:
        begin
          if (to_decel)
            state_r <= ST_DECEL;
          else if (enter_delay)
            state_r <= ST_DELAY;
          else if (enter_off)
            state_r <= ST_OFF;
        end
        ST_DECEL:
        begin
          if (enter_delay)
            state_r <= ST_DELAY;
          else if (enter_off)
            state_r <= ST_OFF;
        end
        ST_DELAY:
        begin
          if (delay_done)
            state_r <= ST_OFF;
        end
        ST_OFF:
        begin
          if (restart)
            state_r <= ST_RUN;
        end
        default: state_r <= ST_OFF;
      endcase
    end
  end

  // Shut-off delay counter
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dly_cnt_r <= 16'h0000;
    else if (enter_delay)
      dly_cnt_r <= par_s_r.delay;
    else if (state_r == ST_DELAY && eval_r)
      dly_cnt_r <= dly_cnt_r - 16'h0001;
  end

  // Freefall lift qualification at the stop event
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      comp_ok_r <= 1'b0;
    else if (leave_run)
      comp_ok_r <= at_zero && (par_s_r.comp != 16'h0000) && (par_s_r.delay != 16'h0000);
    else if (restart)
      comp_ok_r <= 1'b0;
  end

  // Upward travel during the delay
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      lift_r <= 16'h0000;
    else if (restart)
      lift_r <= 16'h0000;
    else if (state_r == ST_DELAY && eval_r && comp_ok_r && lift_r < par_s_r.comp)
      lift_r <= lift_r + 16'h0001;
  end

  // Internal model speed command
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      model_r <= 16'h0000;
    else if (state_r == ST_RUN && !stop_event)
      model_r <= host_speed_cmd;
    else if (to_decel)
      model_r <= speed_s_r;
    else if (state_r == ST_DECEL && eval_r)
      model_r <= (model_r > step_r) ? model_r - step_r : 16'h0000;
    else if (state_r != ST_DECEL && state_r != ST_RUN)
      model_r <= 16'h0000;
  end

  // ==============================
  // Registered outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      drive_enable <= 1'b0;
      dyn_brake <= 1'b1;
      brake_interlock_output <= 1'b0;
      fault_output <= 1'b1;
    end
    else
    begin
      drive_enable <= (state_r != ST_OFF);
      dyn_brake <= (state_r == ST_OFF);
      brake_interlock_output <= (state_r == ST_RUN) && !stop_event;
      fault_output <= !alarm_act_r;
    end
  end

  // Display code and warning flag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      forced_stop_warning <= 1'b0;
      display_code <= CODE_NONE;
    end
    else
    begin
      forced_stop_warning <= !forced_stop_input && !alarm_act_r;
      if (alarm_act_r)
        display_code <= alarm_no_r;
      else if (!forced_stop_input)
        display_code <= CODE_WARN;
      else
        display_code <= CODE_NONE;
    end
  end

  // Speed and lift outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      model_speed_cmd <= 16'h0000;
      lift_offset <= 16'h0000;
    end
    else
    begin
      model_speed_cmd <= model_r;
      lift_offset <= lift_r;
    end
  end
endmodule : fss_seq

// File: fss_seq_assertions.sv
// Purpose: Port checks for the forced stop sequencer.
// Assumes: One clock domain, aresetn active low.
// Notes: Bound to fss_seq below the module.
`timescale 1ns/10ps

// ==============================
// Checker
module fss_seq_assertions
  import fss_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic forced_stop_input,
  input wire fss_pkg::fss_alarm_t alarm_in,
  input wire logic link_lost_db,
  input wire logic drive_enable,
  input wire logic dyn_brake,
  input wire logic brake_interlock_output,
  input wire logic fault_output,
  input wire logic forced_stop_warning,
  input wire logic [7:0] display_code,
  input wire logic [15:0] model_speed_cmd,
  input wire logic [15:0] lift_offset
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Stop request seen with no alarm pending
  sequence s_stop_req;
    $fell(forced_stop_input) && fault_output && !alarm_in.req;
  endsequence
  // Model command frozen for a while
  sequence s_hold8;
    $stable(model_speed_cmd)[*8];
  endsequence
  a_alarm_fault: assert property (alarm_in.req |-> ##2 !fault_output)
    else $error("fault output not low after alarm");
  a_alarm_lock: assert property ($fell(fault_output) |-> ##[0:1] !brake_interlock_output)
    else $error("interlock held during alarm");
  a_warn_code: assert property (forced_stop_warning |-> display_code == CODE_WARN)
    else $error("warning without warning code");
  a_warn_rise: assert property (s_stop_req |-> ##[1:2] forced_stop_warning)
    else $error("no warning after stop request");
  a_db_drive_off: assert property (link_lost_db |-> ##[1:2] !drive_enable)
    else $error("drive on after direct brake event");
  a_off_brake: assert property ($fell(drive_enable) |-> ##[0:1] dyn_brake)
    else $error("drive off without dynamic brake");
  a_lock_first: assert property ($fell(drive_enable) |-> !brake_interlock_output)
    else $error("drive off before interlock drop");
  a_lift_step: assert property ($changed(lift_offset) |->
    lift_offset == $past(lift_offset) + 16'h0001 || lift_offset == 16'h0000)
    else $error("lift offset jumped");
  a_ramp_hold: assert property (forced_stop_warning && $changed(model_speed_cmd) |=> s_hold8)
    else $error("model changed twice in one control cycle");
endmodule : fss_seq_assertions

bind fss_seq fss_seq_assertions fss_seq_assertions_i (.aclk(aclk), .aresetn(aresetn),
  .forced_stop_input(forced_stop_input), .alarm_in(alarm_in), .link_lost_db(link_lost_db),
  .drive_enable(drive_enable), .dyn_brake(dyn_brake), .brake_interlock_output(brake_interlock_output),
  .fault_output(fault_output), .forced_stop_warning(forced_stop_warning), .display_code(display_code),
  .model_speed_cmd(model_speed_cmd), .lift_offset(lift_offset));

// File: fss_seq_tb.sv
// Purpose: Self-checking bench for the forced stop sequencer.
// Assumes: 200 MHz clock, AXI4-Lite register access.
// Notes: Register rows first, then stop scenarios.
`timescale 1ns/10ps

// ==============================
// Bench
module fss_seq_tb;
  import fss_pkg::*;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] r;} fss_row_t;
  localparam fss_row_t ROWS [11] = '{'{1'b0, 8'h00, 32'h2, RESP_OKAY}, '{1'b0, 8'h04, 32'h64, RESP_OKAY},
    '{1'b0, 8'h08, 32'h32, RESP_OKAY}, '{1'b0, 8'h0C, 32'h0, RESP_OKAY}, '{1'b0, 8'h10, 32'h0, RESP_OKAY},
    '{1'b0, 8'h20, 32'h0, RESP_SLVERR}, '{1'b1, 8'h0C, 32'h5, RESP_OKAY}, '{1'b0, 8'h0C, 32'h5, RESP_OKAY},
    '{1'b1, 8'h0C, 32'h0, RESP_OKAY}, '{1'b1, 8'h24, 32'h0, RESP_SLVERR}, '{1'b1, 8'h1C, 32'hFF, RESP_OKAY}};
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bvalid, bready = 1'b0, awready, wready, arready;
  logic arvalid = 1'b0, rvalid, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp, resp;
  logic fsi = 1'b1, link_lost = 1'b0, link_db = 1'b0, sto = 1'b0;
  logic [15:0] speed, host = 16'h0000, model, lift, m1, m2, lmax;
  fss_alarm_t alarm = '0;
  logic drv, dbr, lock, fault, warn;
  logic [7:0] disp;
  logic [31:0] d;
  int num_errors = 0, tests_run = 0, cyc = 0, n;
  // Clock
  always #2.5 aclk = ~aclk;

  fss_seq fss_seq_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .forced_stop_input(fsi),
    .speed_meas(speed), .host_speed_cmd(host), .alarm_in(alarm), .link_lost(link_lost),
    .link_lost_db(link_db), .sto_active(sto), .drive_enable(drv), .dyn_brake(dbr),
    .brake_interlock_output(lock), .fault_output(fault), .forced_stop_warning(warn),
    .display_code(disp), .model_speed_cmd(model), .lift_offset(lift));
  fss_motor_model fss_motor_model_i (.aclk(aclk), .aresetn(aresetn), .drive_enable(drv),
    .model_speed_cmd(model), .speed_meas(speed));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk

  task automatic close_out;
    $display("errors %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  // Hang guard
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      num_errors++;
      close_out();
    end
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    logic ah, wh, b;
    ah = 1'b0;
    wh = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ah && wh))
    begin
      @(negedge aclk);
      ah = ah | (awvalid & awready);
      wh = wh | (wvalid & wready);
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    do
    begin
      @(negedge aclk);
      b = bvalid;
      r = bresp;
      @(posedge aclk);
    end while (!b);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    logic t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      t = arvalid & arready;
      @(posedge aclk);
    end while (!t);
    arvalid <= 1'b0;
    do
    begin
      @(negedge aclk);
      t = rvalid;
      v = rdata;
      r = rresp;
      @(posedge aclk);
    end while (!t);
    rready <= 1'b0;
  endtask : axi_rd

  task automatic wait_drv(input logic v, output int k);
    k = 0;
    lmax = 16'h0000;
    while (drv !== v && k < 20000)
    begin
      @(negedge aclk);
      if (lift > lmax) lmax = lift;
      k++;
    end
    chk("drive_wait", v, drv);
  endtask : wait_drv

  task automatic run_up(input logic [15:0] s);
    @(posedge aclk);
    host <= s;
    wait_drv(1'b1, n);
    repeat (400) @(negedge aclk);
  endtask : run_up

  // Main sequence
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ROWS[i])
    begin
      if (ROWS[i].wr)
        axi_wr(ROWS[i].a, ROWS[i].d, resp);
      else
      begin
        axi_rd(ROWS[i].a, d, resp);
        chk("rdata", ROWS[i].d, d);
      end
      chk("resp", {30'h0, ROWS[i].r}, {30'h0, resp});
    end
    // Ramp only with digit 2 and speed control
    for (int i = 0; i < 3; i++)
    begin
      d = (i == 0) ? 32'h2 : (i == 1) ? 32'h0 : 32'h12;
      axi_wr(OFF_CTRL, d, resp);
      run_up(16'h03E8);
      @(posedge aclk) fsi <= 1'b0;
      wait_drv(1'b0, n);
      chk("ramp_long", (i == 0), (n > 1500));
      chk("dbrake", 1'b1, dbr);
      @(posedge aclk) fsi <= 1'b1;
    end
    axi_wr(OFF_CTRL, 32'h2, resp);
    run_up(16'h03E8);
    @(posedge aclk) fsi <= 1'b0;
    repeat (3) @(negedge aclk);
    chk("warn", 1'b1, warn);
    chk("code", CODE_WARN, disp);
    chk("lock", 1'b0, lock);
    for (int k = 0; k < 3; k++)
    begin
      m1 = m2;
      m2 = model;
      n = 0;
      while (model === m2 && n < 400)
      begin
        @(negedge aclk);
        n++;
      end
      m2 = model;
    end
    chk("step", 32'(RATED_SPEED / DECEL_RST), 32'(m1 - m2));
    @(posedge aclk) sto <= 1'b1;
    n = 0;
    while (fault !== 1'b0 && n < 400)
    begin
      @(negedge aclk);
      n++;
    end
    chk("sto_code", CODE_STO, disp);
    wait_drv(1'b0, n);
    @(posedge aclk);
    sto <= 1'b0;
    fsi <= 1'b1;
    axi_wr(OFF_CTRL, 32'h102, resp);
    run_up(16'h03E8);
    @(posedge aclk) alarm <= '{req: 1'b1, is_db: 1'b0, cause: 1'b1, num: 8'h42};
    @(posedge aclk);
    alarm.req <= 1'b0;
    host <= 16'h07D0;
    repeat (3) @(negedge aclk);
    chk("fault", 1'b0, fault);
    chk("alarm_no", 8'h42, disp);
    chk("lock_alarm", 1'b0, lock);
    repeat (400) @(negedge aclk);
    chk("host_ignored", 1'b1, model <= 16'h03E8);
    axi_wr(OFF_CTRL, 32'h102, resp);
    repeat (3) @(negedge aclk);
    chk("clear_refused", 1'b0, fault);
    @(posedge aclk) alarm.cause <= 1'b0;
    axi_wr(OFF_CTRL, 32'h102, resp);
    repeat (3) @(negedge aclk);
    chk("clear_done", 1'b1, fault);
    // Brake-type alarm while the alarm ramp still runs
    @(posedge aclk) alarm <= '{req: 1'b1, is_db: 1'b1, cause: 1'b0, num: 8'h51};
    @(posedge aclk) alarm.req <= 1'b0;
    repeat (4) @(negedge aclk);
    chk("db_alarm", 1'b0, drv);
    axi_wr(OFF_CTRL, 32'h102, resp);
    run_up(16'h03E8);
    @(posedge aclk) link_lost <= 1'b1;
    repeat (4) @(negedge aclk);
    chk("link_ramp", 1'b1, drv);
    wait_drv(1'b0, n);
    chk("link_len", 1'b1, n > 1500);
    @(posedge aclk) link_lost <= 1'b0;
    run_up(16'h03E8);
    @(posedge aclk) link_db <= 1'b1;
    repeat (4) @(negedge aclk);
    chk("link_db", 1'b0, drv);
    @(posedge aclk) link_db <= 1'b0;
    axi_wr(OFF_SHUT, 32'h5, resp);
    axi_wr(OFF_COMP, 32'h3, resp);
    run_up(16'h0000);
    @(posedge aclk) fsi <= 1'b0;
    repeat (3) @(negedge aclk);
    chk("delay_lock", 1'b0, lock);
    chk("delay_drive", 1'b1, drv);
    wait_drv(1'b0, n);
    chk("delay_len", 1'b1, n >= 800);
    chk("lift", 16'h0003, lmax);
    // Reset after the drive has stopped, with forced stop still requested
    @(posedge aclk) aresetn <= 1'b0;
    repeat (5) @(negedge aclk);
    chk("rst_lift", 16'h0000, lift);
    chk("rst_code", CODE_NONE, disp);
    @(posedge aclk) aresetn <= 1'b1;
    repeat (2) @(negedge aclk);
    chk("rel_drive", 1'b0, drv);
    chk("rel_warn", 1'b1, warn);
    axi_rd(OFF_SHUT, d, resp);
    chk("rst_shut", 32'h0, d);
    close_out();
  end
endmodule : fss_seq_tb
